// File: ttc_top.sv
// How it works
// - Timers 0 and 1 tick at clock/12, or clock/4 when fast select is set.
// - Mode 0 is 13 bits: high byte over low five bits of low byte.
// - Mode 0 wraps 1FFFh to 0000h and sets the overflow flag.
// - Outside timer 0 split mode, timers 0/1 count only with run set and gate pin high or qualify off.
// - Source select picks time base or falling edges on the count input.
// - Mode 1 is a 16-bit counter; FFFFh to 0000h sets overflow flag.
// - Mode 2 reloads low byte from high byte on FFh overflow, sets flag.
// - Timer 1 in mode 3 holds its count.
// - Timer 0 mode 3: two 8-bit counters; high uses timer 1 run and flag.
// - With timer 0 split, timer 1 runs without run bit or flag.
// - Timer 2 clocks from its pin or the divided clock, while run is set.
// - Capture mode counts up; FFFFh rollover sets timer 2 overflow flag.
// - Capture: trigger falling edge copies count and sets external flag.
// - Autoclear zeroes the timer 2 count with each capture.
// - Up reload: rollover loads count from reload bytes and sets flag.
// - Up reload: trigger edge also reloads and sets external flag.
// - Up/down: trigger pin high counts up, low counts down.
// - Down count from reload value loads FFFFh; each reload sets flag.
// - Up/down reload toggles external flag, which then requests nothing.
// - Baud mode reloads on rollover without flag; trigger sets ext flag.
// - Clock-out mode toggles a 50% output and raises no overflow flag.
// - Clock-out period is four clocks per count of the reload span.
// - Count inputs are sampled per machine cycle; high then low counts.
// - Source select bits sit at mode register bits 2 and 6.
`timescale 1ns/1ps
`default_nettype none

module ttc_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Timer 0 and 1 configuration
    input wire logic [7:0] timer_mode_reg,
    input wire logic timer0_fast_base_sel,
    input wire logic timer1_fast_base_sel,
    input wire logic run_enable0,
    input wire logic run_enable1,
    // Timer 2 configuration
    input wire ttc_pkg::ttc_t2_ctrl_s t2_ctrl,
    // Software access
    input wire ttc_pkg::ttc_wr_s byte_wr,
    input wire ttc_pkg::ttc_flags_s flag_clear,
    // Pins
    input wire logic ext_gate_pin0,
    input wire logic ext_gate_pin1,
    input wire logic count_input0,
    input wire logic count_input1,
    input wire logic timer2_ext_clock_pin,
    input wire logic timer2_trigger_pin,
    // Counter state
    output logic [7:0] count_low_byte0,
    output logic [7:0] count_high_byte0,
    output logic [7:0] count_low_byte1,
    output logic [7:0] count_high_byte1,
    output logic [15:0] t2_count,
    output logic [7:0] capture_reload_low,
    output logic [7:0] capture_reload_high,
    // Flags and events
    output var ttc_pkg::ttc_flags_s flags,
    output logic timer2_irq,
    output logic timer1_baud_tick,
    output logic timer2_baud_tick,
    output logic clock_out
);

    logic [ttc_pkg::PRE_W-1:0] pre_reg;
    logic [7:0] low0_reg, high0_reg, low1_reg, high1_reg;
    logic [15:0] t2_reg, cr_reg;
    ttc_pkg::ttc_flags_s flags_reg;
    logic irq_reg, baud1_reg, baud2_reg, clk_out_reg;

    // Machine cycle and time base strobes
    wire logic [ttc_pkg::PRE_W-1:0] pre_next;
    wire logic tick_fast, tick_slow, tick_half;
    assign pre_next = (pre_reg == ttc_pkg::PRE_LAST) ? '0 : pre_reg + 1'b1;
    assign tick_fast = (pre_reg[1:0] == ttc_pkg::FAST_PHASE);
    assign tick_slow = (pre_reg == ttc_pkg::PRE_LAST);
    assign tick_half = pre_reg[0];

    // Falling edges: count inputs, timer 2 clock pin, trigger pin
    wire logic [3:0] pins;
    wire logic [3:0] fall;
    assign pins = {timer2_trigger_pin, timer2_ext_clock_pin, count_input1, count_input0};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_edge
            ttc_fall_det u_det (
                .sys_clk(sys_clk),
                .rst_b(rst_b),
                .sample(tick_fast),
                .pin(pins[gi]),
                .fall(fall[gi])
            );
        end
    endgenerate

    // Software byte write decode
    wire logic [7:0] wr_hit;
    assign wr_hit = byte_wr.en ? (8'h01 << byte_wr.sel) : 8'h00;

    // Step of a timer 0/1 counter in modes 0 to 2; mode 3 holds
    function automatic logic [16:0] ttc_step(input ttc_pkg::ttc_mode_e mode,
                                             input logic [7:0] hi,
                                             input logic [7:0] lo,
                                             input logic inc);
        logic [16:0] res;
        res = {1'b0, hi, lo};
        if (inc) begin
            case (mode)
                ttc_pkg::TTC_M13: begin
                    res[4:0] = lo[4:0] + 5'h01;
                    if (lo[4:0] == ttc_pkg::PRESCALE_FULL) begin
                        res[16:8] = {1'b0, hi} + 9'h001;
                    end
                end
                ttc_pkg::TTC_M16: res = {1'b0, hi, lo} + 17'h00001;
                ttc_pkg::TTC_RELOAD8: begin
                    if (lo == ttc_pkg::BYTE_FULL) begin
                        res = {1'b1, hi, hi};
                    end else begin
                        res[7:0] = lo + 8'h01;
                    end
                end
                default: res = {1'b0, hi, lo};
            endcase
        end
        return res;
    endfunction

    // Timer 0 and 1 controls
    wire ttc_pkg::ttc_mode_e mode0, mode1;
    wire logic base0, base1, src0, src1, gate_ok0, gate_ok1;
    wire logic split0, inc0, inc1, inc0_high;
    assign mode0 = ttc_pkg::ttc_mode_e'(timer_mode_reg[ttc_pkg::MODE0_LSB +: 2]);
    assign mode1 = ttc_pkg::ttc_mode_e'(timer_mode_reg[ttc_pkg::MODE1_LSB +: 2]);
    assign base0 = timer0_fast_base_sel ? tick_fast : tick_slow;
    assign base1 = timer1_fast_base_sel ? tick_fast : tick_slow;
    assign src0 = timer_mode_reg[ttc_pkg::CSEL0_BIT] ? fall[0] : base0;
    assign src1 = timer_mode_reg[ttc_pkg::CSEL1_BIT] ? fall[1] : base1;
    assign gate_ok0 = ~timer_mode_reg[ttc_pkg::QUAL0_BIT] | ext_gate_pin0;
    assign gate_ok1 = ~timer_mode_reg[ttc_pkg::QUAL1_BIT] | ext_gate_pin1;
    assign split0 = (mode0 == ttc_pkg::TTC_SPLIT);
    assign inc0 = run_enable0 & gate_ok0 & src0;
    // Run bit belongs to the split high byte then
    assign inc1 = (split0 | run_enable1) & gate_ok1 & src1;
    assign inc0_high = split0 & run_enable1 & base0;

    wire logic [16:0] step0, step1;
    assign step0 = ttc_step(mode0, high0_reg, low0_reg, inc0);
    assign step1 = ttc_step(mode1, high1_reg, low1_reg, inc1);

    // Split mode byte counters
    wire logic [7:0] low0_split, high0_split;
    wire logic ovf0_split, ovf0_high;
    assign low0_split = low0_reg + {7'h00, inc0};
    assign ovf0_split = inc0 & (low0_reg == ttc_pkg::BYTE_FULL);
    assign high0_split = high0_reg + {7'h00, inc0_high};
    assign ovf0_high = inc0_high & (high0_reg == ttc_pkg::BYTE_FULL);

    wire logic [7:0] low0_next, high0_next, low1_next, high1_next;
    wire logic set0, set1;
    assign low0_next = wr_hit[ttc_pkg::BYTE_LOW0] ? byte_wr.data
                     : (split0 ? low0_split : step0[7:0]);
    assign high0_next = wr_hit[ttc_pkg::BYTE_HIGH0] ? byte_wr.data
                      : (split0 ? high0_split : step0[15:8]);
    assign low1_next = wr_hit[ttc_pkg::BYTE_LOW1] ? byte_wr.data : step1[7:0];
    assign high1_next = wr_hit[ttc_pkg::BYTE_HIGH1] ? byte_wr.data : step1[15:8];
    assign set0 = split0 ? ovf0_split : step0[16];
    // Timer 1 loses its flag to the split high byte
    assign set1 = split0 ? ovf0_high : step1[16];

    // Timer 2 mode decode
    wire logic t2_src, inc2, trig, baud_act, clk_act, quiet, cap_act, ud_act;
    wire logic cnt_full, up_ovf;
    // Clock-out counts every other clock for four clocks per step pair
    assign t2_src = t2_ctrl.t2_source_sel ? fall[2]
                  : (clk_act ? tick_half
                  : (t2_ctrl.t2_fast_base_sel ? tick_fast : tick_slow));
    assign inc2 = t2_ctrl.t2_run_enable & t2_src;
    assign trig = t2_ctrl.trigger_enable & fall[3];
    assign baud_act = t2_ctrl.rx_baud_sel | t2_ctrl.tx_baud_sel;
    assign clk_act = t2_ctrl.clock_out_enable & ~t2_ctrl.t2_source_sel
                   & ~t2_ctrl.capture_reload_sel;
    assign quiet = baud_act | clk_act;
    assign cap_act = t2_ctrl.capture_reload_sel & ~baud_act;
    assign ud_act = ~t2_ctrl.capture_reload_sel & t2_ctrl.updown_enable & ~quiet;
    assign cnt_full = (t2_reg == ttc_pkg::WORD_FULL);
    assign up_ovf = inc2 & cnt_full;

    logic [15:0] t2_calc, t2_next, cr_next;
    logic tf2_set, timer2_external_flag_set, timer2_external_flag_tog, roll;

    always_comb begin
        t2_calc = t2_reg;
        cr_next = cr_reg;
        tf2_set = 1'b0;
        timer2_external_flag_set = 1'b0;
        timer2_external_flag_tog = 1'b0;
        roll = 1'b0;
        if (cap_act) begin
            if (inc2) begin
                t2_calc = t2_reg + 16'h0001;
            end
            tf2_set = up_ovf;
            if (trig) begin
                cr_next = t2_reg;
                timer2_external_flag_set = 1'b1;
                if (t2_ctrl.capture_autoclear) begin
                    t2_calc = ttc_pkg::WORD_RST;
                end
            end
        end else if (ud_act) begin
            if (inc2 && timer2_trigger_pin) begin
                if (cnt_full) begin
                    t2_calc = cr_reg;
                    tf2_set = 1'b1;
                    timer2_external_flag_tog = 1'b1;
                end else begin
                    t2_calc = t2_reg + 16'h0001;
                end
            end else if (inc2) begin
                if (t2_reg == cr_reg) begin
                    t2_calc = ttc_pkg::WORD_FULL;
                    tf2_set = 1'b1;
                    timer2_external_flag_tog = 1'b1;
                end else begin
                    t2_calc = t2_reg - 16'h0001;
                end
            end
        end else begin
            if (inc2) begin
                t2_calc = cnt_full ? cr_reg : t2_reg + 16'h0001;
            end
            roll = up_ovf;
            tf2_set = up_ovf & ~quiet;
            if (trig) begin
                timer2_external_flag_set = 1'b1;
                if (!quiet) begin
                    t2_calc = cr_reg;
                end
            end
        end
        // Software writes take precedence over counting
        t2_next = t2_calc;
        if (wr_hit[ttc_pkg::BYTE_T2_LOW]) begin
            t2_next[7:0] = byte_wr.data;
        end
        if (wr_hit[ttc_pkg::BYTE_T2_HIGH]) begin
            t2_next[15:8] = byte_wr.data;
        end
        if (wr_hit[ttc_pkg::BYTE_CR_LOW]) begin
            cr_next[7:0] = byte_wr.data;
        end
        if (wr_hit[ttc_pkg::BYTE_CR_HIGH]) begin
            cr_next[15:8] = byte_wr.data;
        end
    end

    // Flags: a set in the clearing cycle wins
    ttc_pkg::ttc_flags_s flags_next;
    assign flags_next.overflow_flag0 = set0
        | (flags_reg.overflow_flag0 & ~flag_clear.overflow_flag0);
    assign flags_next.overflow_flag1 = set1
        | (flags_reg.overflow_flag1 & ~flag_clear.overflow_flag1);
    assign flags_next.timer2_overflow_flag = tf2_set
        | (flags_reg.timer2_overflow_flag & ~flag_clear.timer2_overflow_flag);
    assign flags_next.timer2_external_flag = timer2_external_flag_set
        | ((flags_reg.timer2_external_flag ^ timer2_external_flag_tog)
           & ~flag_clear.timer2_external_flag);

    // External flag is silent in up/down mode
    wire logic irq_next;
    assign irq_next = flags_reg.timer2_overflow_flag
                    | (flags_reg.timer2_external_flag & ~ud_act);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_reg <= '0;
            low0_reg <= ttc_pkg::BYTE_RST;
            high0_reg <= ttc_pkg::BYTE_RST;
            low1_reg <= ttc_pkg::BYTE_RST;
            high1_reg <= ttc_pkg::BYTE_RST;
            t2_reg <= ttc_pkg::WORD_RST;
            cr_reg <= ttc_pkg::WORD_RST;
            flags_reg <= '0;
            irq_reg <= 1'b0;
            baud1_reg <= 1'b0;
            baud2_reg <= 1'b0;
            clk_out_reg <= 1'b0;
        end else begin
            pre_reg <= pre_next;
            low0_reg <= low0_next;
            high0_reg <= high0_next;
            low1_reg <= low1_next;
            high1_reg <= high1_next;
            t2_reg <= t2_next;
            cr_reg <= cr_next;
            flags_reg <= flags_next;
            irq_reg <= irq_next;
            baud1_reg <= step1[16];
            baud2_reg <= roll & baud_act;
            clk_out_reg <= clk_out_reg ^ (roll & clk_act);
        end
    end

    assign count_low_byte0 = low0_reg;
    assign count_high_byte0 = high0_reg;
    assign count_low_byte1 = low1_reg;
    assign count_high_byte1 = high1_reg;
    assign t2_count = t2_reg;
    assign capture_reload_low = cr_reg[7:0];
    assign capture_reload_high = cr_reg[15:8];
    assign flags = flags_reg;
    assign timer2_irq = irq_reg;
    assign timer1_baud_tick = baud1_reg;
    assign timer2_baud_tick = baud2_reg;
    assign clock_out = clk_out_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_slow_base_gap: assert property (tick_slow |=> !tick_slow [*8])
        else $error("slow time base ticked early");

    a_mode0_upper: assert property ((mode0 == ttc_pkg::TTC_M13) && !byte_wr.en
        |=> low0_reg[7:5] == $past(low0_reg[7:5]))
        else $error("mode 0 touched the unused low bits");

    a_mode0_wrap: assert property ((mode0 == ttc_pkg::TTC_M13) && inc0 && !byte_wr.en
        && high0_reg == 8'hFF && low0_reg[4:0] == 5'h1F
        |=> high0_reg == 8'h00 && low0_reg[4:0] == 5'h00 && flags_reg.overflow_flag0)
        else $error("mode 0 wrap wrong");

    a_run_hold: assert property (!run_enable0 && !split0 && !byte_wr.en
        |=> $stable({high0_reg, low0_reg}))
        else $error("timer 0 moved while stopped");

    a_mode1_wrap: assert property ((mode0 == ttc_pkg::TTC_M16) && inc0 && !byte_wr.en
        && {high0_reg, low0_reg} == 16'hFFFF
        |=> {high0_reg, low0_reg} == 16'h0000 && flags_reg.overflow_flag0)
        else $error("mode 1 wrap wrong");

    a_mode2_reload: assert property ((mode0 == ttc_pkg::TTC_RELOAD8) && inc0
        && !byte_wr.en && low0_reg == 8'hFF
        |=> low0_reg == $past(high0_reg) && flags_reg.overflow_flag0)
        else $error("mode 2 reload wrong");

    a_t1_freeze: assert property ((mode1 == ttc_pkg::TTC_SPLIT) && !byte_wr.en
        |=> $stable({high1_reg, low1_reg}))
        else $error("timer 1 moved in mode 3");

    a_t2_roll_flag: assert property (cap_act && up_ovf && !byte_wr.en
        |=> flags_reg.timer2_overflow_flag && t2_reg == 16'h0000)
        else $error("capture mode rollover wrong");

    a_capture_copy: assert property (cap_act && trig && !byte_wr.en
        |=> cr_reg == $past(t2_reg) && flags_reg.timer2_external_flag)
        else $error("capture did not copy count");

    a_down_reload: assert property (ud_act && inc2 && !timer2_trigger_pin
        && t2_reg == cr_reg && !byte_wr.en
        |=> t2_reg == 16'hFFFF && flags_reg.timer2_overflow_flag)
        else $error("down reload wrong");

    a_updown_quiet: assert property (ud_act && !flags_reg.timer2_overflow_flag
        |=> !timer2_irq)
        else $error("up/down external flag raised a request");

    a_baud_noflag: assert property (baud_act && up_ovf && !byte_wr.en
        && !flags_reg.timer2_overflow_flag
        |=> !flags_reg.timer2_overflow_flag && t2_reg == $past(cr_reg)
            && timer2_baud_tick)
        else $error("baud rollover wrong");

    a_set_wins: assert property (set0 && flag_clear.overflow_flag0
        |=> flags_reg.overflow_flag0)
        else $error("flag set lost to clear");

    c_split_high_ovf: cover property (ovf0_high);
    c_capture: cover property (cap_act && trig);
    c_updown_down: cover property (ud_act && inc2 && !timer2_trigger_pin);
    c_clock_toggle: cover property (roll && clk_act);

endmodule // ttc_top

`default_nettype wire

// File: ttc_pkg.sv
package ttc_pkg;

    // Time base dividers, in system clocks per count
    localparam int DIV_SLOW = 12;
    localparam int DIV_FAST = 4;
    localparam int PRE_W = 4;
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(DIV_SLOW - 1);
    localparam logic [1:0] FAST_PHASE = 2'(DIV_FAST - 1);

    // Field positions in the timer mode register
    localparam int MODE0_LSB = 0;
    localparam int CSEL0_BIT = 2;
    localparam int QUAL0_BIT = 3;
    localparam int MODE1_LSB = 4;
    localparam int CSEL1_BIT = 6;
    localparam int QUAL1_BIT = 7;

    // Byte select codes for software writes
    localparam logic [2:0] BYTE_LOW0 = 3'h0;
    localparam logic [2:0] BYTE_HIGH0 = 3'h1;
    localparam logic [2:0] BYTE_LOW1 = 3'h2;
    localparam logic [2:0] BYTE_HIGH1 = 3'h3;
    localparam logic [2:0] BYTE_T2_LOW = 3'h4;
    localparam logic [2:0] BYTE_T2_HIGH = 3'h5;
    localparam logic [2:0] BYTE_CR_LOW = 3'h6;
    localparam logic [2:0] BYTE_CR_HIGH = 3'h7;

    // Values after reset and full-count values
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [15:0] WORD_FULL = 16'hFFFF;
    localparam logic [7:0] BYTE_FULL = 8'hFF;
    localparam logic [4:0] PRESCALE_FULL = 5'h1F;

    typedef enum logic [1:0] {
        TTC_M13 = 2'b00,
        TTC_M16 = 2'b01,
        TTC_RELOAD8 = 2'b10,
        TTC_SPLIT = 2'b11
    } ttc_mode_e;

    typedef struct packed {
        logic t2_source_sel;
        logic t2_run_enable;
        logic t2_fast_base_sel;
        logic capture_reload_sel;
        logic trigger_enable;
        logic capture_autoclear;
        logic updown_enable;
        logic rx_baud_sel;
        logic tx_baud_sel;
        logic clock_out_enable;
    } ttc_t2_ctrl_s;

    typedef struct packed {
        logic en;
        logic [2:0] sel;
        logic [7:0] data;
    } ttc_wr_s;

    typedef struct packed {
        logic overflow_flag0;
        logic overflow_flag1;
        logic timer2_overflow_flag;
        logic timer2_external_flag;
    } ttc_flags_s;

endpackage

// File: ttc_fall_det.sv
`timescale 1ns/1ps
`default_nettype none

module ttc_fall_det (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Sampling
    input wire logic sample,
    input wire logic pin,
    // Result
    output logic fall
);

    logic smp_reg;
    logic fall_reg;
    wire logic fall_next;

    // High at the last sample, low at this one
    assign fall_next = sample & smp_reg & ~pin;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            smp_reg <= 1'b0;
            fall_reg <= 1'b0;
        end else begin
            if (sample) begin
                smp_reg <= pin;
            end
            fall_reg <= fall_next;
        end
    end

    assign fall = fall_reg;

endmodule // ttc_fall_det

`default_nettype wire

// File: ttc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module ttc_pin_model (
    // Clock
    input wire logic sys_clk,
    // Pins driven toward the timers
    output logic count_input0,
    output logic count_input1,
    output logic timer2_ext_clock_pin,
    output logic timer2_trigger_pin,
    output logic ext_gate_pin0,
    output logic ext_gate_pin1
);
    logic [5:0] pin_q = 6'h3F;

    assign {ext_gate_pin1, ext_gate_pin0, timer2_trigger_pin} = pin_q[5:3];
    assign {timer2_ext_clock_pin, count_input1, count_input0} = pin_q[2:0];

    // Gate and direction levels
    task automatic set_pin(input int idx, input logic val);
        @(negedge sys_clk);
        pin_q[idx] = val;
    endtask

    // Each level held two machine cycles so a sample lands in both
    task automatic fall_pulse(input int idx);
        @(negedge sys_clk);
        pin_q[idx] = 1'b0;
        repeat (8) @(negedge sys_clk);
        pin_q[idx] = 1'b1;
        repeat (8) @(negedge sys_clk);
    endtask
endmodule // ttc_pin_model

`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] tm = 8'h00;
    logic f0 = 1'b0;
    logic f1 = 1'b0;
    logic r0 = 1'b0;
    logic r1 = 1'b0;
    ttc_pkg::ttc_t2_ctrl_s t2c = '0;
    ttc_pkg::ttc_wr_s bw = '0;
    ttc_pkg::ttc_flags_s fc = '0;
    ttc_pkg::ttc_flags_s flags;
    wire logic g0, g1, c0, c1, t2k, trg, irq, b1t, b2t, ck_o;
    logic [7:0] l0, h0, l1, h1, crl, crh;
    logic [15:0] t2_count;
    int n_fail = 0;
    int cmp_count = 0;
    int n_b1 = 0;
    int n_b2 = 0;

    always #5 sys_clk = ~sys_clk;

    // Baud ticks stand one cycle, so count them as they pass
    always @(posedge sys_clk) begin
        n_b1 <= n_b1 + int'(b1t);
        n_b2 <= n_b2 + int'(b2t);
    end

    ttc_pin_model u_pins (.sys_clk(sys_clk), .count_input0(c0), .count_input1(c1),
        .timer2_ext_clock_pin(t2k), .timer2_trigger_pin(trg), .ext_gate_pin0(g0),
        .ext_gate_pin1(g1));

    ttc_top u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .timer_mode_reg(tm),
        .timer0_fast_base_sel(f0), .timer1_fast_base_sel(f1), .run_enable0(r0),
        .run_enable1(r1), .t2_ctrl(t2c), .byte_wr(bw), .flag_clear(fc),
        .ext_gate_pin0(g0), .ext_gate_pin1(g1), .count_input0(c0), .count_input1(c1),
        .timer2_ext_clock_pin(t2k), .timer2_trigger_pin(trg), .count_low_byte0(l0),
        .count_high_byte0(h0), .count_low_byte1(l1), .count_high_byte1(h1),
        .t2_count(t2_count), .capture_reload_low(crl), .capture_reload_high(crh),
        .flags(flags), .timer2_irq(irq), .timer1_baud_tick(b1t), .timer2_baud_tick(b2t),
        .clock_out(ck_o));

    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
            n_fail++;
        end
    endtask

    task automatic wr(input logic [2:0] sel, input logic [7:0] d);
        @(negedge sys_clk);
        bw = '{en: 1'b1, sel: sel, data: d};
        @(negedge sys_clk);
        bw.en = 1'b0;
    endtask

    task automatic w16(input logic [2:0] sel, input logic [15:0] v);
        wr(sel, v[7:0]);
        wr(sel + 3'h1, v[15:8]);
    endtask

    task automatic clr(input ttc_pkg::ttc_flags_s m);
        @(negedge sys_clk);
        fc = m;
        @(negedge sys_clk);
        fc = '0;
    endtask

    // Run bit high for exactly n rising edges
    task automatic run_win(input int which, input int n);
        @(negedge sys_clk);
        case (which)
            0: r0 = 1'b1;
            1: r1 = 1'b1;
            default: t2c.t2_run_enable = 1'b1;
        endcase
        repeat (n) @(negedge sys_clk);
        {r0, r1, t2c.t2_run_enable} = 3'h0;
    endtask

    task automatic done(input string name);
        $display("test %s finished, %0d mismatches so far", name, n_fail);
    endtask

    initial begin
        repeat (100000) @(posedge sys_clk);
        n_fail++;
        conclude();
    end

    initial begin
        repeat (20) @(negedge sys_clk);
        rst_b = 1'b1;
        tm = 8'h01;
        run_win(0, 120);
        chk({h0, l0}, 16'h000A, "slow base");
        f0 = 1'b1;
        w16(ttc_pkg::BYTE_LOW0, 16'h0000);
        run_win(0, 120);
        chk({h0, l0}, 16'h001E, "fast base");
        tm = 8'h00;
        w16(ttc_pkg::BYTE_LOW0, 16'hFFFF);
        run_win(0, 4);
        chk({h0, l0}, 16'h00E0, "13-bit wrap");
        run_win(0, 4);
        chk(flags.overflow_flag0, 1'b1, "flag0 sticky");
        clr('{overflow_flag0: 1'b1, default: 1'b0});
        chk(flags.overflow_flag0, 1'b0, "flag0 clear");
        done("modes 0 and 1 base");
        f1 = 1'b1;
        tm = 8'h10;
        w16(ttc_pkg::BYTE_LOW1, 16'hFFFF);
        run_win(1, 4);
        chk({h1, l1}, 16'h0000, "16-bit wrap");
        chk(flags.overflow_flag1, 1'b1, "flag1");
        tm = 8'h02;
        wr(ttc_pkg::BYTE_HIGH0, 8'hF0);
        wr(ttc_pkg::BYTE_LOW0, 8'hFF);
        run_win(0, 8);
        chk({h0, l0}, 16'hF0F1, "8-bit reload");
        chk(flags.overflow_flag0, 1'b1, "reload flag");
        chk(n_b1[15:0], 16'h0001, "timer 1 baud tick");
        done("16-bit and reload");
        tm = 8'h09;
        w16(ttc_pkg::BYTE_LOW0, 16'h0000);
        u_pins.set_pin(4, 1'b0);
        run_win(0, 40);
        chk({h0, l0}, 16'h0000, "gated off");
        u_pins.set_pin(4, 1'b1);
        run_win(0, 40);
        chk({h0, l0}, 16'h000A, "gated on");
        tm = 8'h31;
        w16(ttc_pkg::BYTE_LOW1, 16'h1234);
        run_win(1, 40);
        chk({h1, l1}, 16'h1234, "timer1 frozen");
        tm = 8'h03;
        clr('{overflow_flag1: 1'b1, default: 1'b0});
        w16(ttc_pkg::BYTE_LOW0, 16'hFE00);
        run_win(1, 8);
        chk({h0, l0}, 16'h0000, "split high byte");
        chk(flags.overflow_flag1, 1'b1, "split flag");
        done("gate and split");
        tm = 8'h05;
        w16(ttc_pkg::BYTE_LOW0, 16'h0000);
        r0 = 1'b1;
        repeat (3) u_pins.fall_pulse(0);
        r0 = 1'b0;
        chk({h0, l0}, 16'h0003, "pin edges");
        t2c.capture_reload_sel = 1'b1;
        t2c.trigger_enable = 1'b1;
        t2c.t2_fast_base_sel = 1'b1;
        w16(ttc_pkg::BYTE_T2_LOW, 16'h1234);
        u_pins.fall_pulse(3);
        chk({crh, crl}, 16'h1234, "capture");
        chk({flags.timer2_external_flag, irq}, 16'h0003, "capture flag");
        t2c.capture_autoclear = 1'b1;
        w16(ttc_pkg::BYTE_T2_LOW, 16'h5678);
        u_pins.fall_pulse(3);
        chk(t2_count, 16'h0000, "autoclear");
        w16(ttc_pkg::BYTE_T2_LOW, 16'hFFFF);
        run_win(2, 4);
        chk(t2_count, 16'h0000, "capture rollover");
        chk(flags.timer2_overflow_flag, 1'b1, "capture overflow flag");
        done("pins and capture");
        t2c = '0;
        t2c.t2_fast_base_sel = 1'b1;
        clr('1);
        w16(ttc_pkg::BYTE_CR_LOW, 16'hFFF0);
        w16(ttc_pkg::BYTE_T2_LOW, 16'hFFFF);
        run_win(2, 4);
        chk(t2_count, 16'hFFF0, "up reload");
        chk(flags.timer2_overflow_flag, 1'b1, "reload flag");
        t2c.trigger_enable = 1'b1;
        w16(ttc_pkg::BYTE_T2_LOW, 16'h1234);
        u_pins.fall_pulse(3);
        t2c.trigger_enable = 1'b0;
        chk(t2_count, 16'hFFF0, "trigger reload");
        chk(flags.timer2_external_flag, 1'b1, "trigger ext flag");
        clr('1);
        t2c.rx_baud_sel = 1'b1;
        w16(ttc_pkg::BYTE_T2_LOW, 16'hFFFF);
        run_win(2, 4);
        chk(t2_count, 16'hFFF0, "baud reload");
        chk(flags.timer2_overflow_flag, 1'b0, "baud no flag");
        t2c.rx_baud_sel = 1'b0;
        u_pins.set_pin(3, 1'b0);
        t2c.updown_enable = 1'b1;
        w16(ttc_pkg::BYTE_T2_LOW, 16'hFFF0);
        run_win(2, 4);
        chk(t2_count, 16'hFFFF, "down reload");
        chk(flags.timer2_external_flag, 1'b1, "ext toggle");
        u_pins.set_pin(3, 1'b1);
        run_win(2, 4);
        chk(t2_count, 16'hFFF0, "up overflow");
        chk(flags.timer2_external_flag, 1'b0, "ext toggle back");
        done("timer 2 reload");
        // Span of two counts: toggle every four clocks
        t2c = '0;
        t2c.clock_out_enable = 1'b1;
        clr('1);
        w16(ttc_pkg::BYTE_CR_LOW, 16'hFFFE);
        w16(ttc_pkg::BYTE_T2_LOW, 16'hFFFE);
        run_win(2, 4);
        chk(ck_o, 1'b1, "clock out high");
        chk(flags.timer2_overflow_flag, 1'b0, "clock out no flag");
        run_win(2, 4);
        chk(ck_o, 1'b0, "clock out low");
        chk(t2_count, 16'hFFFE, "clock out reload");
        chk(n_b2[15:0], 16'h0001, "timer 2 baud tick");
        done("clock out");
        conclude();
    end
endmodule // testbench

`default_nettype wire
